// file: core/trxi_pkg.sv
// constants and types shared by the table-read and xor execution block
package trxi_pkg;

	// ------------------------------------------------------------
	// widths
	// ------------------------------------------------------------
	localparam int unsigned DATA_W = 8;
	localparam int unsigned PTR_BITS = 3;
	localparam int unsigned ROM_AW = 11;
	localparam int unsigned ROM_DW = 14;
	localparam int unsigned ROM_DEPTH = 2048;
	localparam int unsigned FR_AW = 7;
	localparam int unsigned TABLE_HIGH_DATA_W = 6;

	// ------------------------------------------------------------
	// field positions of a program word
	// ------------------------------------------------------------
	localparam int unsigned TBL_LO_MSB = 7;
	localparam int unsigned TBL_HI_LSB = 8;
	localparam int unsigned TBL_HI_MSB = 13;

	// ------------------------------------------------------------
	// reset values and timing
	// ------------------------------------------------------------
	localparam logic [DATA_W-1:0] ACC_RST = 8'h00;
	localparam logic [DATA_W-1:0] TABLE_HIGH_POINTER_RST = 8'h00;
	localparam logic [DATA_W-1:0] TABLE_HIGH_DATA_RST = 8'h00;
	localparam logic [ROM_DW-1:0] ROM_RDATA_RST = 14'h0000;
	localparam int unsigned TBL_CYCLES = 2;
	localparam int unsigned ONE_CYCLE = 1;

	// ------------------------------------------------------------
	// operations
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		TRXI_OP_TABLE_READ,
		TRXI_OP_TIMER0_READ,
		TRXI_OP_XOR_REG,
		TRXI_OP_XOR_IMM
	} trxi_op_t;

	typedef enum logic {
		TRXI_ST_IDLE,
		TRXI_ST_TABLE_WAIT
	} trxi_state_t;

endpackage

// file: core/trxi_rom_if.sv
// program memory read port between the core and its memory
interface trxi_rom_if;
	logic rd_en;
	logic [trxi_pkg::ROM_AW-1:0] addr;
	logic [trxi_pkg::ROM_DW-1:0] rdata;

	modport core (output rd_en, output addr, input rdata);
	modport mem (input rd_en, input addr, output rdata);
endinterface

// file: core/trxi_rom.sv
// program memory with a load port and a registered read port
module trxi_rom (
	input wire logic ref_clk_i,
	input wire logic resetn_i,
	input wire logic ce_i,
	input wire logic prog_we_i,
	input wire logic [trxi_pkg::ROM_AW-1:0] prog_addr_i,
	input wire logic [trxi_pkg::ROM_DW-1:0] prog_wdata_i,
	trxi_rom_if.mem rom
);
	import trxi_pkg::*;

	// array kept outside the state struct: no reset, infers as a memory
	logic [ROM_DW-1:0] mem_r [ROM_DEPTH];
	logic [ROM_DW-1:0] rdata_r;

	// ------------------------------------------------------------
	// load and read
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk_i) begin
		if (ce_i && prog_we_i) begin
			mem_r[prog_addr_i] <= prog_wdata_i;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (!resetn_i) begin
			rdata_r <= ROM_RDATA_RST;
		end else if (ce_i && rom.rd_en) begin
			rdata_r <= mem_r[rom.addr];
		end
	end

	assign rom.rdata = rdata_r;
endmodule

// file: core/trxi_core.sv
// execution of table read, timer0 mode read and the two xor operations
// Operation
// - table read addresses program memory with pointer bits 2..0 above the accumulator and loads word bits 7..0 into the accumulator.
// - table read puts word bits 13..8 into table high data bits 5..0, takes two cycles and leaves flags alone.
// - timer0 mode read copies the timer0 mode register into the accumulator in one cycle without touching flags.
// - xor with register combines accumulator and file register 0..127, result to accumulator if dest is 0, else back to the register.
// - xor with register changes only the zero flag and finishes in one cycle.
// - xor with immediate combines accumulator with an 8-bit immediate, result always to accumulator, only zero flag, one cycle.
module trxi_core (
	input wire logic ref_clk_i,
	input wire logic resetn_i,
	input wire logic ce_i,
	input wire logic instr_valid_i,
	input wire trxi_pkg::trxi_op_t opcode_i,
	input wire logic [trxi_pkg::FR_AW-1:0] fr_addr_i,
	input wire logic dest_i,
	input wire logic [trxi_pkg::DATA_W-1:0] imm_i,
	input wire logic [trxi_pkg::DATA_W-1:0] file_rdata_i,
	input wire logic [trxi_pkg::DATA_W-1:0] timer0_mode_register_i,
	input wire logic table_high_pointer_we_i,
	input wire logic [trxi_pkg::DATA_W-1:0] table_high_pointer_wdata_i,
	input wire logic prog_we_i,
	input wire logic [trxi_pkg::ROM_AW-1:0] prog_addr_i,
	input wire logic [trxi_pkg::ROM_DW-1:0] prog_wdata_i,
	output logic instr_ready_o,
	output logic done_o,
	output logic [trxi_pkg::DATA_W-1:0] acc_o,
	output logic [trxi_pkg::DATA_W-1:0] table_high_pointer_o,
	output logic [trxi_pkg::DATA_W-1:0] table_high_data_o,
	output logic z_o,
	output logic file_we_o,
	output logic [trxi_pkg::FR_AW-1:0] file_waddr_o,
	output logic [trxi_pkg::DATA_W-1:0] file_wdata_o
);
	import trxi_pkg::*;

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef struct packed {
		trxi_state_t state;
		logic [DATA_W-1:0] acc;
		logic [DATA_W-1:0] table_high_pointer;
		logic [DATA_W-1:0] table_high_data;
		logic z;
		logic file_we;
		logic [FR_AW-1:0] file_waddr;
		logic [DATA_W-1:0] file_wdata;
		logic done;
	} trxi_regs_t;

	localparam trxi_regs_t REGS_RST = '{
		state: TRXI_ST_IDLE,
		acc: ACC_RST,
		table_high_pointer: TABLE_HIGH_POINTER_RST,
		table_high_data: TABLE_HIGH_DATA_RST,
		z: 1'b0,
		file_we: 1'b0,
		file_waddr: '0,
		file_wdata: '0,
		done: 1'b0
	};

	function automatic logic trxi_is_xor(input trxi_op_t op);
		return (op == TRXI_OP_XOR_REG) || (op == TRXI_OP_XOR_IMM);
	endfunction

	trxi_regs_t st_r;
	trxi_regs_t st_nxt;
	trxi_rom_if rom_if ();
	logic accept;

	// ------------------------------------------------------------
	// program memory
	// ------------------------------------------------------------
	trxi_rom u_rom (
		.ref_clk_i(ref_clk_i),
		.resetn_i(resetn_i),
		.ce_i(ce_i),
		.prog_we_i(prog_we_i),
		.prog_addr_i(prog_addr_i),
		.prog_wdata_i(prog_wdata_i),
		.rom(rom_if.mem)
	);

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	assign accept = instr_valid_i && (st_r.state == TRXI_ST_IDLE);

	always_comb begin
		logic [DATA_W-1:0] xor_res;
		xor_res = st_r.acc ^ ((opcode_i == TRXI_OP_XOR_IMM) ? imm_i : file_rdata_i);
		st_nxt = st_r;
		st_nxt.done = 1'b0;
		st_nxt.file_we = 1'b0;
		rom_if.rd_en = 1'b0;
		rom_if.addr = {st_r.table_high_pointer[PTR_BITS-1:0], st_r.acc};
		// pointer changes only through its own load port
		if (table_high_pointer_we_i) begin
			st_nxt.table_high_pointer = table_high_pointer_wdata_i;
		end
		case (st_r.state)
			TRXI_ST_IDLE: begin
				if (accept) begin
					if (opcode_i == TRXI_OP_TABLE_READ) begin
						rom_if.rd_en = 1'b1;
						st_nxt.state = TRXI_ST_TABLE_WAIT;
					end else if (opcode_i == TRXI_OP_TIMER0_READ) begin
						st_nxt.acc = timer0_mode_register_i;
						st_nxt.done = 1'b1;
					end else if (trxi_is_xor(opcode_i)) begin
						st_nxt.z = (xor_res == '0);
						st_nxt.done = 1'b1;
						if (opcode_i == TRXI_OP_XOR_REG && dest_i) begin
							st_nxt.file_we = 1'b1;
							st_nxt.file_waddr = fr_addr_i;
							st_nxt.file_wdata = xor_res;
						end else begin
							st_nxt.acc = xor_res;
						end
					end
				end
			end
			TRXI_ST_TABLE_WAIT: begin
				// memory read data are registered, hence the second cycle
				st_nxt.acc = rom_if.rdata[TBL_LO_MSB:0];
				st_nxt.table_high_data = {{(DATA_W - TABLE_HIGH_DATA_W){1'b0}}, rom_if.rdata[TBL_HI_MSB:TBL_HI_LSB]};
				st_nxt.done = 1'b1;
				st_nxt.state = TRXI_ST_IDLE;
			end
			default: begin
				st_nxt.state = TRXI_ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge ref_clk_i) begin
		if (!resetn_i) begin
			st_r <= REGS_RST;
		end else if (ce_i) begin
			st_r <= st_nxt;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign instr_ready_o = (st_r.state == TRXI_ST_IDLE);
	assign done_o = st_r.done;
	assign acc_o = st_r.acc;
	assign table_high_pointer_o = st_r.table_high_pointer;
	assign table_high_data_o = st_r.table_high_data;
	assign z_o = st_r.z;
	assign file_we_o = st_r.file_we;
	assign file_waddr_o = st_r.file_waddr;
	assign file_wdata_o = st_r.file_wdata;

	// ------------------------------------------------------------
	// checks (all assume ce_i stays high over the span)
	// ------------------------------------------------------------
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!resetn_i);

	sequence s_tbl_start;
		ce_i && accept && opcode_i == TRXI_OP_TABLE_READ;
	endsequence

	sequence s_tbl_run;
		s_tbl_start ##1 ce_i;
	endsequence

	sequence s_xor_start;
		ce_i && accept && trxi_is_xor(opcode_i);
	endsequence

	a_tbl_addr_issue: assert property (s_tbl_start |-> rom_if.rd_en && rom_if.addr == {table_high_pointer_o[PTR_BITS-1:0], acc_o})
		else $error("table read address wrong");
	a_tbl_low_byte: assert property (s_tbl_run |=> acc_o == $past(rom_if.rdata[TBL_LO_MSB:0]))
		else $error("table read low byte not in accumulator");
	a_tbl_high_bits: assert property (s_tbl_run |=> table_high_data_o == {2'b00, $past(rom_if.rdata[TBL_HI_MSB:TBL_HI_LSB])})
		else $error("table read high bits wrong");
	a_tbl_two_cycles: assert property (s_tbl_start |=> !done_o && !instr_ready_o && $stable(z_o) ##1 done_o && $stable(z_o))
		else $error("table read timing or flag wrong");
	a_timer0_copy: assert property (ce_i && accept && opcode_i == TRXI_OP_TIMER0_READ |=> acc_o == $past(timer0_mode_register_i) && done_o && $stable(z_o))
		else $error("timer0 mode read wrong");
	a_xor_reg_acc: assert property (ce_i && accept && opcode_i == TRXI_OP_XOR_REG && !dest_i |=> acc_o == $past(acc_o ^ file_rdata_i) && !file_we_o)
		else $error("xor to accumulator wrong");
	a_xor_reg_back: assert property (ce_i && accept && opcode_i == TRXI_OP_XOR_REG && dest_i |=> file_we_o && file_wdata_o == $past(acc_o ^ file_rdata_i) && file_waddr_o == $past(fr_addr_i) && $stable(acc_o))
		else $error("xor write back wrong");
	a_xor_one_cycle: assert property (s_xor_start |=> done_o && instr_ready_o)
		else $error("xor not single cycle");
	a_xor_imm_acc: assert property (ce_i && accept && opcode_i == TRXI_OP_XOR_IMM |=> acc_o == $past(acc_o ^ imm_i) && !file_we_o)
		else $error("xor immediate wrong");
	a_zero_flag: assert property (s_xor_start |=>
		z_o == ($past(acc_o ^ ((opcode_i == TRXI_OP_XOR_IMM) ? imm_i : file_rdata_i)) == 8'h00))
		else $error("zero flag wrong");
	a_tbl_ptr_kept: assert property ((s_tbl_start and !table_high_pointer_we_i) ##1 (ce_i && !table_high_pointer_we_i) |->
		$stable(table_high_pointer_o) ##1 $stable(table_high_pointer_o))
		else $error("table read changed pointer");

	// ------------------------------------------------------------
	// load port, stall and side effects
	// ------------------------------------------------------------
	// second table cycle refuses new work, result lands at its end
	sequence s_tbl_done;
		(!done_o && !instr_ready_o) ##1 (done_o && instr_ready_o);
	endsequence

	a_tbl_done_seq: assert property (s_tbl_start |=> s_tbl_done)
		else $error("table read handshake wrong");
	a_tbl_refuse: assert property (s_tbl_run |-> !rom_if.rd_en)
		else $error("second table cycle issued a read");
	a_tbl_no_write: assert property (s_tbl_start |=> !file_we_o ##1 !file_we_o)
		else $error("table read wrote a file register");
	a_timer0_side: assert property (ce_i && accept && opcode_i == TRXI_OP_TIMER0_READ |=>
		!file_we_o && $stable(table_high_data_o))
		else $error("timer0 mode read side effect");
	a_xor_table_high_data_kept: assert property (s_xor_start |=> $stable(table_high_data_o))
		else $error("xor changed table high data");
	a_table_high_pointer_load: assert property (ce_i && table_high_pointer_we_i |=> table_high_pointer_o == $past(table_high_pointer_wdata_i))
		else $error("pointer load lost");
	// stall freezes every register, so a held request cannot slip through
	a_ce_freeze: assert property (!ce_i |=> $stable({acc_o, table_high_pointer_o, table_high_data_o, z_o, done_o}))
		else $error("state moved while clock enable low");
endmodule

// file: verification/tb_top.sv
// self-checking bench for the table-read and xor execution block
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import trxi_pkg::*;
`define CHK(n, e, g) check(n, 16'(e), 16'(g))

	// ------------------------------------------------------------
	// stimulus, reference state and counters
	// ------------------------------------------------------------
	logic ref_clk_i = 1'b0, resetn_i = 1'b0, ce_i = 1'b1, instr_valid_i = 1'b0, dest_i = 1'b0;
	logic table_high_pointer_we_i = 1'b0, prog_we_i = 1'b0, instr_ready_o, done_o, z_o, file_we_o;
	trxi_op_t opcode_i = TRXI_OP_XOR_IMM;
	logic [FR_AW-1:0] fr_addr_i = 7'h00, file_waddr_o;
	logic [DATA_W-1:0] imm_i = 8'h00, timer0_mode_register_i = 8'h00, table_high_pointer_wdata_i = 8'h00, file_rdata_i;
	logic [DATA_W-1:0] acc_o, table_high_pointer_o, table_high_data_o, file_wdata_o, m_acc = 8'h00, m_table_high_pointer = 8'h00, m_table_high_data = 8'h00;
	logic [ROM_AW-1:0] prog_addr_i = 11'h000;
	logic [ROM_DW-1:0] prog_wdata_i = 14'h0000;
	logic [DATA_W-1:0] fregs [128];
	logic [ROM_DW-1:0] rom_m [ROM_DEPTH];
	logic m_z = 1'b0;
	logic [31:0] seed = 32'h6204_188f;
	int error_cnt = 0, samples_checked = 0;

	// outside file register answers combinationally
	assign file_rdata_i = fregs[fr_addr_i];

	initial begin
		forever #5 ref_clk_i = ~ref_clk_i;
	end

	trxi_core dut (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .ce_i(ce_i), .instr_valid_i(instr_valid_i),
		.opcode_i(opcode_i), .fr_addr_i(fr_addr_i), .dest_i(dest_i), .imm_i(imm_i), .file_rdata_i(file_rdata_i),
		.timer0_mode_register_i(timer0_mode_register_i), .table_high_pointer_we_i(table_high_pointer_we_i), .table_high_pointer_wdata_i(table_high_pointer_wdata_i), .prog_we_i(prog_we_i),
		.prog_addr_i(prog_addr_i), .prog_wdata_i(prog_wdata_i), .instr_ready_o(instr_ready_o), .done_o(done_o),
		.acc_o(acc_o), .table_high_pointer_o(table_high_pointer_o), .table_high_data_o(table_high_data_o), .z_o(z_o), .file_we_o(file_we_o),
		.file_waddr_o(file_waddr_o), .file_wdata_o(file_wdata_o));

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	// only the low three pointer bits reach the address
	function automatic logic [ROM_AW-1:0] tbl_addr(input logic [7:0] p, input logic [7:0] a);
		return {p[2:0], a};
	endfunction

	task automatic check(input string n, input logic [15:0] e, input logic [15:0] g);
		samples_checked++;
		if (g !== e) begin
			error_cnt++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// reset values seen right after any release of reset
	task automatic rst_chk();
		`CHK("rst_ready", 1'b1, instr_ready_o);
		`CHK("rst_done", 1'b0, done_o);
		`CHK("rst_acc", ACC_RST, acc_o);
		`CHK("rst_table_high_data", TABLE_HIGH_DATA_RST, table_high_data_o);
		`CHK("rst_ptr", TABLE_HIGH_POINTER_RST, table_high_pointer_o);
		`CHK("rst_zero", 1'b0, z_o);
		`CHK("rst_fwe", 1'b0, file_we_o);
	endtask

	// iv[8] forces the operand and the pointer load value 8'hfa (upper bits must be ignored)
	task automatic exec(input trxi_op_t op, input logic d, input logic pw, input logic [8:0] iv);
		logic [7:0] opnd, old_p, res;
		logic [13:0] w;
		logic wexp;
		seed = lfsr(seed);
		opcode_i = op;
		dest_i = d;
		instr_valid_i = 1'b1;
		fr_addr_i = seed[6:0];
		imm_i = iv[8] ? iv[7:0] : seed[15:8];
		timer0_mode_register_i = seed[23:16];
		table_high_pointer_we_i = pw;
		table_high_pointer_wdata_i = iv[8] ? 8'hfa : seed[31:24];
		if (iv[8])
			fregs[seed[6:0]] = iv[7:0];
		opnd = (op == TRXI_OP_XOR_REG) ? fregs[seed[6:0]] : imm_i;
		old_p = m_table_high_pointer;
		if (pw)
			m_table_high_pointer = table_high_pointer_wdata_i;
		res = m_acc ^ opnd;
		wexp = (op == TRXI_OP_XOR_REG) && d;
		@(posedge ref_clk_i);
		@(negedge ref_clk_i);
		case (op)
			TRXI_OP_TABLE_READ: begin
				`CHK("ready_mid", 1'b0, instr_ready_o);
				`CHK("done_mid", 1'b0, done_o);
				table_high_pointer_we_i = 1'b0;
				@(posedge ref_clk_i);
				@(negedge ref_clk_i);
				w = rom_m[tbl_addr(old_p, m_acc)];
				m_acc = w[7:0];
				m_table_high_data = {2'b00, w[13:8]};
			end
			TRXI_OP_TIMER0_READ: m_acc = timer0_mode_register_i;
			default: begin
				m_z = (res == 8'h00);
				if (wexp)
					fregs[fr_addr_i] = res;
				else
					m_acc = res;
			end
		endcase
		`CHK("done", 1'b1, done_o);
		`CHK("ready", 1'b1, instr_ready_o);
		`CHK("acc", m_acc, acc_o);
		`CHK("table_high_data", m_table_high_data, table_high_data_o);
		`CHK("zero", m_z, z_o);
		`CHK("ptr", m_table_high_pointer, table_high_pointer_o);
		`CHK("fwe", wexp, file_we_o);
		if (wexp) begin
			`CHK("waddr", fr_addr_i, file_waddr_o);
			`CHK("wdata", res, file_wdata_o);
		end
	endtask

	// ------------------------------------------------------------
	// main sequence and watchdog
	// ------------------------------------------------------------
	initial begin
		repeat (20) @(negedge ref_clk_i);
		resetn_i = 1'b1;
		rst_chk();
		for (int a = 0; a < ROM_DEPTH; a++) begin
			seed = lfsr(seed);
			prog_we_i = 1'b1;
			prog_addr_i = a[10:0];
			prog_wdata_i = (a == 'h234) ? 14'h35aa : seed[13:0];
			rom_m[a] = prog_wdata_i;
			fregs[a[6:0]] = seed[21:14];
			@(negedge ref_clk_i);
		end
		prog_we_i = 1'b0;
		// pointer 8'hfa and acc 8'h34 must fetch word 11'h234
		exec(TRXI_OP_XOR_IMM, 1'b0, 1'b1, 9'h134);
		exec(TRXI_OP_TABLE_READ, 1'b0, 1'b0, 9'h000);
		exec(TRXI_OP_XOR_IMM, 1'b0, 1'b0, {1'b1, m_acc});
		exec(TRXI_OP_TABLE_READ, 1'b0, 1'b1, 9'h000);
		exec(TRXI_OP_TIMER0_READ, 1'b0, 1'b0, 9'h000);
		exec(TRXI_OP_XOR_REG, 1'b1, 1'b0, {1'b1, m_acc});
		exec(TRXI_OP_XOR_REG, 1'b0, 1'b0, {1'b1, m_acc});
		// a held request while the clock enable is low must not run
		ce_i = 1'b0;
		@(negedge ref_clk_i);
		`CHK("acc_frozen", m_acc, acc_o);
		ce_i = 1'b1;
		instr_valid_i = 1'b0;
		table_high_pointer_we_i = 1'b0;
		@(negedge ref_clk_i);
		`CHK("idle_done", 1'b0, done_o);
		`CHK("idle_acc", m_acc, acc_o);
		// reset again mid-run: state returns, program memory keeps its words
		resetn_i = 1'b0;
		@(negedge ref_clk_i);
		resetn_i = 1'b1;
		m_acc = ACC_RST;
		m_table_high_pointer = TABLE_HIGH_POINTER_RST;
		m_table_high_data = TABLE_HIGH_DATA_RST;
		m_z = 1'b0;
		rst_chk();
		for (int i = 0; i < 400; i++) begin
			seed = lfsr(seed);
			exec(trxi_op_t'(seed[1:0]), seed[2], seed[3], (seed[7:4] == 4'h0) ? {1'b1, m_acc} : 9'h000);
		end
		print_verdict();
	end

	initial begin
		repeat (10000) @(posedge ref_clk_i);
		error_cnt++;
		print_verdict();
	end
endmodule
